// >>> csa_cluster.sv
// Ten-cell arithmetic cluster: carry-select chains, cluster controls and register access.
// Assumes a classic Wishbone master on clk_i and neighbouring clusters on the carry ports.
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`include "csa_defines.svh"

// Contract
// - Five two-input lookups per cell
// - Parallel sums for carry zero and one
// - Cluster carry-in picks chain, chain picks sum
// - Each chain carry selects own carry candidate
// - Both carries forwarded to next bit within each group of five
// - Chain select resolved at cells five, ten
// - Chain may start at any cell
// - Clusters link for wider arithmetic
// - Final carry leaves as ordinary output
// - Registered and unregistered sum both available
// - Register bypassable or captures the sum each enabled clock
// - Counter enable, up/down come per cell
// - Cluster-wide sync clear and load
// - Cluster add/subtract select is dynamic
// - Add/subtract drives every chain-head carry and every cell's operand b
// - Preset loads high asynchronously
// - Clear wins over preset
// - Two async clears, one preset per cluster
// - Optional chip clear overrides all
// - Subtract inverts operand b, carry one
// - Two clock enables gate register updates
module csa_cluster
#(
	parameter int CELLS = 10,
	parameter int GROUP = 5
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Cluster-wide controls
	input wire csa_pkg::csa_ctrl_s ctrl_i,
	input wire logic chip_wide_clear_n_i,
	// Per-cell local data
	input wire csa_pkg::csa_cell_in_s [CELLS-1:0] cell_in_i,
	// Carry link to neighbouring clusters
	input wire logic cluster_carry_in_i,
	output logic cluster_carry_out_o,
	output logic carry_chain_zero_out_o,
	output logic carry_chain_one_out_o,
	// Sums
	output logic [CELLS-1:0] sum_comb_o,
	output logic [CELLS-1:0] sum_reg_o
);

	localparam int NGROUPS = (CELLS + GROUP - 1) / GROUP;

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic chip_clr_en_r;
	logic [CELLS-1:0] start_r;
	logic [CELLS-1:0] bypass_r;
	logic [CELLS-1:0] clksel_r;
	logic [CELLS-1:0] clrsel_r;

	// Bus handshake
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic bus_req;
	logic bus_wr;

	// Chain wiring
	logic [CELLS-1:0] cin_zero;
	logic [CELLS-1:0] cin_one;
	logic [CELLS-1:0] cout_zero;
	logic [CELLS-1:0] cout_one;
	logic [CELLS-1:0] cell_sel;
	logic [CELLS-1:0] invert_b;
	logic [NGROUPS-1:0] group_sel;
	logic [CELLS-1:0] sum_comb;
	logic [CELLS-1:0] sum_reg;
	logic [CELLS-1:0] cell_out;
	logic final_carry;
	logic chip_clear;
	csa_pkg::csa_cell_ctl_s [CELLS-1:0] cell_ctl;

	// Byte-lane merge of a narrow register with write data
	function automatic logic [CELLS-1:0] lane_merge(input logic [CELLS-1:0] old_v, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] tmp;
		tmp = {{(32-CELLS){1'b0}}, old_v};
		for (int k = 0; k < 4; k++)
		begin
			if (sel[k])
				tmp[k*8 +: 8] = d[k*8 +: 8];
		end
		lane_merge = tmp[CELLS-1:0];
	endfunction

	// Address decode used by both the write and read paths
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	assign bus_req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack high
	assign bus_wr = bus_req & wb_we_i & ack_r;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req & ~ack_r;
	end

	// Read mux; unmapped addresses read zero and still ack
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit(wb_adr_i, `CSA_OFS_CTRL))
			rdata_nxt[`CSA_CTRL_CHIPCLR_BIT] = chip_clr_en_r;
		else if (hit(wb_adr_i, `CSA_OFS_START))
			rdata_nxt[CELLS-1:0] = start_r;
		else if (hit(wb_adr_i, `CSA_OFS_BYPASS))
			rdata_nxt[CELLS-1:0] = bypass_r;
		else if (hit(wb_adr_i, `CSA_OFS_CLKSEL))
			rdata_nxt[CELLS-1:0] = clksel_r;
		else if (hit(wb_adr_i, `CSA_OFS_CLRSEL))
			rdata_nxt[CELLS-1:0] = clrsel_r;
		else if (hit(wb_adr_i, `CSA_OFS_SUMREG))
			rdata_nxt[CELLS-1:0] = sum_reg;
		else if (hit(wb_adr_i, `CSA_OFS_SUMCOMB))
			rdata_nxt[CELLS:0] = {final_carry, sum_comb};
	end

	// Read data captured with the ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= 32'h0000_0000;
		else if (bus_req & ~ack_r)
			rdata_r <= rdata_nxt;
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ************************************************************
	// Configuration writes
	// ************************************************************
	// Build-time chip clear option, kept as a bit software sets once
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chip_clr_en_r <= `CSA_RST_CTRL;
		else if (bus_wr && hit(wb_adr_i, `CSA_OFS_CTRL) && wb_sel_i[0])
			chip_clr_en_r <= wb_dat_i[`CSA_CTRL_CHIPCLR_BIT];
	end

	// Chain start positions
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			start_r <= `CSA_RST_START;
		else if (bus_wr && hit(wb_adr_i, `CSA_OFS_START))
			start_r <= lane_merge(start_r, wb_dat_i, wb_sel_i);
	end

	// Register bypass per cell
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bypass_r <= `CSA_RST_BYPASS;
		else if (bus_wr && hit(wb_adr_i, `CSA_OFS_BYPASS))
			bypass_r <= lane_merge(bypass_r, wb_dat_i, wb_sel_i);
	end

	// Clock enable pairing per cell
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clksel_r <= `CSA_RST_CLKSEL;
		else if (bus_wr && hit(wb_adr_i, `CSA_OFS_CLKSEL))
			clksel_r <= lane_merge(clksel_r, wb_dat_i, wb_sel_i);
	end

	// Asynchronous clear choice per cell
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clrsel_r <= `CSA_RST_CLRSEL;
		else if (bus_wr && hit(wb_adr_i, `CSA_OFS_CLRSEL))
			clrsel_r <= lane_merge(clrsel_r, wb_dat_i, wb_sel_i);
	end

	// ************************************************************
	// Chain select per group of five
	// ************************************************************
	// Only group ends feed the next select, so the
	// critical path skips the cells inside each group
	assign chip_clear = chip_clr_en_r & ~chip_wide_clear_n_i;

	generate
		for (genvar g = 0; g < NGROUPS; g++)
		begin : g_grp
			if (g == 0)
			begin : g_first
				assign group_sel[g] = cluster_carry_in_i;
			end
			else
			begin : g_next
				localparam int LAST = g * GROUP - 1;
				assign group_sel[g] = group_sel[g-1] ? cout_one[LAST] : cout_zero[LAST];
			end
		end
	endgenerate

	// ************************************************************
	// Cells and chain wiring
	// ************************************************************
	generate
		for (genvar i = 0; i < CELLS; i++)
		begin : g_cell
			// Per-cell up/down flips direction on top of addnsub
			assign invert_b[i] = ctrl_i.addnsub ^ ~cell_in_i[i].count_up;
			assign cell_sel[i] = group_sel[i / GROUP];

			if (i == 0)
			begin : g_head
				// Chain head gets the subtract carry, else fresh chains
				assign cin_zero[i] = start_r[i] ? invert_b[i] : 1'b0;
				assign cin_one[i] = start_r[i] ? invert_b[i] : 1'b1;
			end
			else if (i % GROUP == 0)
			begin : g_grp_head
				assign cin_zero[i] = start_r[i] ? invert_b[i] : 1'b0;
				assign cin_one[i] = start_r[i] ? invert_b[i] : 1'b1;
			end
			else
			begin : g_body
				// Start cell forces both chains equal so select no longer matters
				assign cin_zero[i] = start_r[i] ? invert_b[i] : cout_zero[i-1];
				assign cin_one[i] = start_r[i] ? invert_b[i] : cout_one[i-1];
			end

			// Resolve the cluster controls for this cell
			assign cell_ctl[i].clk_en = ctrl_i.clk_en[clksel_r[i]];
			assign cell_ctl[i].async_clear = ctrl_i.async_clear[clrsel_r[i]];
			assign cell_ctl[i].async_preset = ctrl_i.async_preset;
			assign cell_ctl[i].chip_clear = chip_clear;
			assign cell_ctl[i].sync_clear = ctrl_i.sync_clear;
			assign cell_ctl[i].sync_load = ctrl_i.sync_load;

			csa_logic_cell u_cell
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.din_i(cell_in_i[i]),
				.ctl_i(cell_ctl[i]),
				.invert_b_i(invert_b[i]),
				.carry_chain_zero_in_i(cin_zero[i]),
				.carry_chain_one_in_i(cin_one[i]),
				.chain_sel_i(cell_sel[i]),
				.carry_chain_zero_out_o(cout_zero[i]),
				.carry_chain_one_out_o(cout_one[i]),
				.sum_comb_o(sum_comb[i]),
				.sum_reg_o(sum_reg[i])
			);

			// Bypass shows the combinational sum on the main output
			assign cell_out[i] = bypass_r[i] ? sum_comb[i] : sum_reg[i];
		end
	endgenerate

	// ************************************************************
	// Outputs toward neighbours
	// ************************************************************
	// Final carry resolved by the last group's select
	assign final_carry = group_sel[NGROUPS-1] ? cout_one[CELLS-1] : cout_zero[CELLS-1];
	// Combinational on purpose: the next cluster chains off it
	assign cluster_carry_out_o = final_carry;
	assign carry_chain_zero_out_o = cout_zero[CELLS-1];
	assign carry_chain_one_out_o = cout_one[CELLS-1];

	// Both forms at once; combinational output honours bypass
	assign sum_comb_o = cell_out;
	assign sum_reg_o = sum_reg;

endmodule

// >>> csa_cluster_asserts.sv
// Checker for the arithmetic cluster, watching top-level ports only.
// Assumes a bind into csa_cluster, one clock, synchronous reset.
module csa_cluster_chk
#(
	parameter int CELLS = 10
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Controls, data, sums
	input wire csa_pkg::csa_ctrl_s ctrl_i,
	input wire logic chip_wide_clear_n_i,
	input wire csa_pkg::csa_cell_in_s [CELLS-1:0] cell_in_i,
	input wire logic [CELLS-1:0] sum_reg_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [CELLS-1:0] load_vec;
	logic quiet;

	// Gather per-cell load data
	always_comb
	begin
		for (int i = 0; i < CELLS; i++)
			load_vec[i] = cell_in_i[i].load_d;
	end

	// No asynchronous control active, so only clocked updates matter
	assign quiet = chip_wide_clear_n_i && ctrl_i.async_clear == 2'b00 && !ctrl_i.async_preset;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ************************************************************
	// Bus handshake
	// ************************************************************
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i >= 8'h1c
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:11] == 21'h0)
		else $error("upper read bits not zero");

	// ************************************************************
	// Cell registers
	// ************************************************************
	// Two cycles: a clear released under a held preset only shows at the next clock edge
	a_preset_high: assert property (
		(chip_wide_clear_n_i && ctrl_i.async_clear == 2'b00 && ctrl_i.async_preset) [*2] |-> &sum_reg_o)
		else $error("preset did not load ones");
	a_clear_wins: assert property (
		chip_wide_clear_n_i && ctrl_i.async_clear == 2'b11 && ctrl_i.async_preset |-> sum_reg_o == '0)
		else $error("clear lost against preset");
	a_hold_disabled: assert property (
		(ctrl_i.clk_en == 2'b00 && quiet) ##1 quiet |-> $stable(sum_reg_o))
		else $error("register moved with enables low");
	a_sync_clear: assert property (
		(ctrl_i.sync_clear && ctrl_i.clk_en == 2'b11 && quiet) ##1 quiet |-> sum_reg_o == '0)
		else $error("sync clear missed");
	a_sync_load: assert property (
		(ctrl_i.sync_load && !ctrl_i.sync_clear && ctrl_i.clk_en == 2'b11 && quiet) ##1 quiet
		|-> sum_reg_o == $past(load_vec))
		else $error("sync load missed");
endmodule

// >>> csa_defines.svh
// Constants of the carry-select arithmetic cluster: offsets, fields, reset values.
// Assumes byte addressing on a 32-bit classic Wishbone bus, one word per register.
`ifndef CSA_DEFINES_SVH
`define CSA_DEFINES_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define CSA_OFS_CTRL 8'h00
`define CSA_OFS_START 8'h04
`define CSA_OFS_BYPASS 8'h08
`define CSA_OFS_CLKSEL 8'h0c
`define CSA_OFS_CLRSEL 8'h10
`define CSA_OFS_SUMREG 8'h14
`define CSA_OFS_SUMCOMB 8'h18

// ************************************************************
// Field positions and reset values
// ************************************************************
`define CSA_CTRL_CHIPCLR_BIT 0
`define CSA_RST_CTRL 1'h0
`define CSA_RST_START 10'h001
`define CSA_RST_BYPASS 10'h000
`define CSA_RST_CLKSEL 10'h000
`define CSA_RST_CLRSEL 10'h000

// ************************************************************
// Lookup function masks, indexed by {x, y}
// ************************************************************
`define CSA_LUT_XOR 4'h6
`define CSA_LUT_AND 4'h8
`define CSA_LUT_OR 4'he

// ************************************************************
// Bus answer timing: ack rises this many cycles after the request
// ************************************************************
`define CSA_ACK_LATENCY 1

`endif

// >>> csa_logic_cell.sv
// One logic cell in dynamic arithmetic mode: five two-input lookups and a register.
// Assumes the cluster supplies chain carries, chain select and resolved controls.
`include "csa_defines.svh"

module csa_logic_cell
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Local data and controls
	input wire csa_pkg::csa_cell_in_s din_i,
	input wire csa_pkg::csa_cell_ctl_s ctl_i,
	input wire logic invert_b_i,
	// Carry chains
	input wire logic carry_chain_zero_in_i,
	input wire logic carry_chain_one_in_i,
	input wire logic chain_sel_i,
	output logic carry_chain_zero_out_o,
	output logic carry_chain_one_out_o,
	// Sums
	output logic sum_comb_o,
	output logic sum_reg_o
);

	// Two-input lookup function
	function automatic logic lookup2(input logic [3:0] mask, input logic x, input logic y);
		lookup2 = mask[{x, y}];
	endfunction

	logic b_eff;
	logic prop;
	logic sum_zero;
	logic sum_one;
	logic gen_k;
	logic prop_k;
	logic sum_r;

	// ************************************************************
	// Lookups: two candidate sums, two carry candidates
	// ************************************************************
	assign b_eff = din_i.operand_b_bit ^ invert_b_i;
	assign prop = lookup2(`CSA_LUT_XOR, din_i.operand_a_bit, b_eff);
	assign sum_zero = lookup2(`CSA_LUT_XOR, prop, carry_chain_zero_in_i);
	assign sum_one = lookup2(`CSA_LUT_XOR, prop, carry_chain_one_in_i);
	assign gen_k = lookup2(`CSA_LUT_AND, din_i.operand_a_bit, b_eff);
	assign prop_k = lookup2(`CSA_LUT_OR, din_i.operand_a_bit, b_eff);

	// Each chain's carry picks its own carry candidate
	assign carry_chain_zero_out_o = carry_chain_zero_in_i ? prop_k : gen_k;
	assign carry_chain_one_out_o = carry_chain_one_in_i ? prop_k : gen_k;

	// Active chain chooses the presented sum
	assign sum_comb_o = chain_sel_i ? sum_one : sum_zero;
	assign sum_reg_o = sum_r;

	// ************************************************************
	// Cell register with asynchronous clear and preset
	// ************************************************************
	// Chip clear beats asynchronous clear, which beats preset
	always_ff @(posedge clk_i or posedge ctl_i.chip_clear or posedge ctl_i.async_clear or posedge ctl_i.async_preset)
	begin
		if (ctl_i.chip_clear)
			sum_r <= 1'b0;
		else if (ctl_i.async_clear)
			sum_r <= 1'b0;
		else if (ctl_i.async_preset)
			sum_r <= 1'b1;
		else if (rst_i)
			sum_r <= 1'b0;
		else if (ctl_i.clk_en)
		begin
			if (ctl_i.sync_clear)
				sum_r <= 1'b0;
			else if (ctl_i.sync_load)
				sum_r <= din_i.load_d;
			else if (din_i.cnt_en)
				sum_r <= sum_comb_o;
		end
	end

endmodule

// >>> csa_pkg.sv
// Types shared by the arithmetic cluster and its logic cells.
// Assumes nothing beyond a SystemVerilog compiler.
package csa_pkg;

	// Cluster-wide control set, all active high except the chip clear
	typedef struct packed {
		logic addnsub;
		logic sync_clear;
		logic sync_load;
		logic [1:0] clk_en;
		logic [1:0] async_clear;
		logic async_preset;
	} csa_ctrl_s;

	// Local data inputs of one logic cell
	typedef struct packed {
		logic operand_a_bit;
		logic operand_b_bit;
		logic cnt_en;
		logic count_up;
		logic load_d;
	} csa_cell_in_s;

	// Per-cell resolved control, as handed to the cell
	typedef struct packed {
		logic clk_en;
		logic async_clear;
		logic async_preset;
		logic chip_clear;
		logic sync_clear;
		logic sync_load;
	} csa_cell_ctl_s;

endpackage

// >>> csa_prev_cluster.sv
// Behavioural model of the preceding cluster in a carry chain.
// Assumes the bench supplies its lower-word operands; answers at once.
module csa_prev_cluster
(
	// Lower-word operands
	input wire logic [9:0] a_i,
	input wire logic [9:0] b_i,
	// Final carry handed up the chain
	output logic carry_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [10:0] total;

	// Plain add; only its carry leaves, as an ordinary signal
	assign total = {1'b0, a_i} + {1'b0, b_i};
	assign carry_o = total[10];
endmodule

// >>> test_carry_select_arith_cell.sv
// Self-checking bench for the ten-cell carry-select cluster.
// Assumes csa_pkg, the cluster, its checker and the neighbour model.
module test_carry_select_arith_cell;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int k; logic [31:0] e;} csa_note_s;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	csa_pkg::csa_ctrl_s ctrl_i = '0;
	logic chip_n = 1'b1;
	csa_pkg::csa_cell_in_s [9:0] cell_in_i = '0;
	logic cin;
	logic ccout;
	logic cz;
	logic co;
	logic [9:0] sum_comb_o;
	logic [9:0] sum_reg_o;
	logic [9:0] pa = 10'h0;
	logic [9:0] pb = 10'h0;
	logic probe = 1'b0;
	int err_total = 0;
	int checks_done = 0;
	csa_note_s q[$];
	csa_note_s note;

	csa_cluster u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctrl_i(ctrl_i), .chip_wide_clear_n_i(chip_n),
		.cell_in_i(cell_in_i), .cluster_carry_in_i(cin), .cluster_carry_out_o(ccout),
		.carry_chain_zero_out_o(cz), .carry_chain_one_out_o(co), .sum_comb_o(sum_comb_o), .sum_reg_o(sum_reg_o));
	csa_prev_cluster u_prev (.a_i(pa), .b_i(pb), .carry_o(cin));

	// 125 MHz clock
	always #4 clk_i = ~clk_i;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One classic cycle; waits for ack under a bound, then idles a cycle
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h3;
		wb_dat_i <= dat;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			err_total++;
			summarize();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Note an expectation and let the monitor compare next edge
	task automatic look(input int k, input logic [31:0] e);
		q.push_back('{k, e});
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic cells(input logic [9:0] a, input logic [9:0] b, input logic u, input logic [9:0] ld);
		for (int i = 0; i < 10; i++)
			cell_in_i[i] <= {a[i], b[i], 1'b1, u, ld[i]};
	endtask

	// Bit-serial reference: chain heads restart the carry
	function automatic logic [10:0] model(logic [9:0] a, logic [9:0] b, logic s, logic u, logic [9:0] st,
		logic ci);
		logic [10:0] r;
		logic c;
		logic h;
		h = s ^ ~u;
		c = ci;
		for (int i = 0; i < 10; i++)
		begin
			if (st[i])
				c = h;
			r[i] = a[i] ^ b[i] ^ h ^ c;
			c = (a[i] & (b[i] ^ h)) | (c & (a[i] ^ b[i] ^ h));
		end
		r[10] = c;
		return r;
	endfunction

	// Raw upper-group chain carries: bit 0 assumes carry zero into cell five, bit 1 carry one
	function automatic logic [1:0] tails(logic [9:0] a, logic [9:0] b, logic h, logic [9:0] st);
		logic [1:0] r;
		logic c;
		for (int k = 0; k < 2; k++)
		begin
			c = (k == 1);
			for (int i = 5; i < 10; i++)
			begin
				if (st[i])
					c = h;
				c = (a[i] & (b[i] ^ h)) | (c & (a[i] ^ b[i] ^ h));
			end
			r[k] = c;
		end
		return r;
	endfunction

	// Oldest note against whatever result shows
	always @(posedge clk_i)
	begin
		if ((wb_ack_o === 1'b1 && wb_we_i === 1'b0) || probe)
		begin
			note = q.pop_front();
			if (note.k == 0)
			begin
				check("sum_comb", {21'h0, ccout, sum_comb_o}, note.e & 32'h7ff);
				check("chain_out", {30'h0, co, cz}, {30'h0, note.e[12:11]});
			end
			else if (note.k == 1)
				check("sum_reg", {22'h0, sum_reg_o}, note.e);
			else
				check("wb_dat", wb_dat_o, note.e);
		end
	end

	// Main sequence
	initial
	begin
		logic [9:0] la;
		logic [9:0] lb;
		logic [9:0] st;
		logic [9:0] ld;
		logic [10:0] ex;
		logic [10:0] ct;
		logic s;
		logic u;
		logic [7:0] adr [8];
		logic [6:0] code [10];
		logic [9:0] ev [10];
		adr = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'hfc};
		code = '{7'h18, 7'h28, 7'h38, 7'h00, 7'h78, 7'h01, 7'h04, 7'h07, 7'h01, 7'h01};
		void'($urandom(38));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values; read-only and unmapped writes ignored
		wb(1'b1, 8'h14, 32'h3ff);
		wb(1'b1, 8'hfc, 32'h3ff);
		for (int i = 0; i < 8; i++)
		begin
			q.push_back('{2, {31'h0, i == 1}});
			wb(1'b0, adr[i], 32'h0);
		end
		// Unregistered sums, random chain heads and linked carry-in
		wb(1'b1, 8'h08, 32'h3ff);
		for (int i = 0; i < 24; i++)
		begin
			la = (i == 0) ? 10'h3ff : 10'($urandom);
			lb = (i == 0) ? 10'h001 : 10'($urandom);
			st = (i < 8) ? 10'h001 : 10'($urandom);
			s = 1'($urandom);
			u = 1'($urandom);
			ct = 11'($urandom) & 11'h3ff;
			wb(1'b1, 8'h04, {22'h0, st});
			pa <= ct[9:0];
			pb <= 10'h3ff - 10'(i & 1);
			ct = {1'b0, ct[9:0]} + {1'b0, 10'h3ff - 10'(i & 1)};
			ctrl_i.addnsub <= s;
			cells(la, lb, u, 10'h0);
			ex = model(la, lb, s, u, st, ct[10]);
			look(0, {19'h0, tails(la, lb, s ^ ~u, st), ex});
			q.push_back('{2, {21'h0, ex}});
			wb(1'b0, 8'h18, 32'h0);
		end
		// Registered path: capture, enables, sync and async controls
		wb(1'b1, 8'h08, 32'h0);
		wb(1'b1, 8'h04, 32'h1);
		wb(1'b1, 8'h00, 32'h1);
		// Every cell steered to the second enable and second clear of each pair
		wb(1'b1, 8'h0c, 32'h3ff);
		wb(1'b1, 8'h10, 32'h3ff);
		q.push_back('{2, 32'h3ff});
		wb(1'b0, 8'h0c, 32'h0);
		q.push_back('{2, 32'h3ff});
		wb(1'b0, 8'h10, 32'h0);
		la = 10'($urandom);
		lb = 10'($urandom);
		ld = 10'($urandom);
		ex = model(la, lb, 1'b0, 1'b1, 10'h001, 1'b0);
		ev = '{ex[9:0], ex[9:0], ld, ld, 10'h0, 10'h3ff, 10'h0, 10'h0, 10'h3ff, 10'h0};
		cells(la, lb, 1'b1, ld);
		for (int i = 0; i < 10; i++)
		begin
			ctrl_i <= {1'b0, code[i]};
			chip_n <= (i != 9);
			@(posedge clk_i);
			look(1, {22'h0, ev[i]});
		end
		summarize();
	end
endmodule

bind csa_cluster csa_cluster_chk #(.CELLS(CELLS)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ctrl_i(ctrl_i), .chip_wide_clear_n_i(chip_wide_clear_n_i), .cell_in_i(cell_in_i), .sum_reg_o(sum_reg_o));
